// ---- rcp_consts.svh ----
// What this block does
// - protection set by one protect byte at a fixed ROM address
// - protect byte all zeros protects every program ROM address
// - byte with only bit zero cleared protects area one only
// - protect byte all ones means no protection, whole ROM open
// - area one spans lowest ROM address to upper bound, inclusive
// - protected addresses refuse programmer reads and writes
`ifndef RCP_CONSTS_SVH
`define RCP_CONSTS_SVH

// bus widths
`define RCP_AW 16
`define RCP_DW 8

// protect byte location
`define RCP_PROT_ADDR 16'hFFDB

// protect byte encodings
`define RCP_CODE_ALL 8'h00
`define RCP_CODE_AREA1 8'hFE
`define RCP_CODE_NONE 8'hFF

// program ROM bounds and protect area one
`define RCP_ROM_LO 16'h0000
`define RCP_AREA1_HI 16'hEFFF

// reset values
`define RCP_ADDR_RST 16'h0000
`define RCP_DATA_RST 8'h00

`endif

// ---- rcp_gate.sv ----
`timescale 1ns/1ps
`include "rcp_consts.svh"

module rcp_gate (
   input wire logic sys_clk_in, // 250 MHz clock
   input wire logic rst_b_in, // async reset, active low
   input wire logic prog_sess_in, // programmer session active
   input wire logic prog_req_in, // access request pulse
   input wire logic prog_we_in, // 1 write, 0 read
   input wire logic [`RCP_AW-1:0] prog_addr_in, // access address
   input wire logic [`RCP_DW-1:0] prog_wdata_in, // write data
   output logic prog_busy_out, // gate not ready for a request
   output logic prog_ack_out, // access done pulse
   output logic prog_deny_out, // access refused pulse
   output logic [`RCP_DW-1:0] prog_rdata_out, // read data
   output logic prog_open_out, // session ready, protection decoded
   output logic [1:0] prot_level_out, // decoded protection level
   output logic rom_req_out, // ROM access pulse
   output logic rom_we_out, // ROM write select
   output logic [`RCP_AW-1:0] rom_addr_out, // ROM address
   output logic [`RCP_DW-1:0] rom_wdata_out, // ROM write data
   input wire logic rom_ack_in, // ROM access done pulse
   input wire logic [`RCP_DW-1:0] rom_rdata_in // ROM read data
);

   rcp_pkg::rcp_state_t state_reg;
   rcp_pkg::rcp_state_t state_next;
   rcp_pkg::rcp_prot_t prot_reg;
   rcp_pkg::rcp_prot_t prot_next;
   logic in_rom;
   logic in_area1;
   logic covered;
   logic take;
   logic deny;
   logic pass;

   // address coverage under the held protection level
   assign in_rom = (prog_addr_in >= `RCP_ROM_LO);
   assign in_area1 = in_rom && (prog_addr_in <= `RCP_AREA1_HI);
   assign covered = (prot_reg == rcp_pkg::RCP_PROT_ALL) ? in_rom :
                    (prot_reg == rcp_pkg::RCP_PROT_AREA1) ?
                    in_area1 :
                    1'b0;
   assign take = (state_reg == rcp_pkg::RCP_READY) && prog_sess_in &&
                 prog_req_in;
   assign deny = take && covered;
   assign pass = take && !covered;

   // protect byte decode, unknown codes fall back to full protection
   always_comb begin
      prot_next = rcp_pkg::RCP_PROT_ALL;
      case (rom_rdata_in)
         `RCP_CODE_AREA1: prot_next = rcp_pkg::RCP_PROT_AREA1;
         `RCP_CODE_NONE: prot_next = rcp_pkg::RCP_PROT_NONE;
         default: prot_next = rcp_pkg::RCP_PROT_ALL;
      endcase
   end

   // sequencing of fetch, idle and forwarded accesses
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         rcp_pkg::RCP_IDLE: begin
            if (prog_sess_in) begin
               state_next = rcp_pkg::RCP_FETCH;
            end
         end
         rcp_pkg::RCP_FETCH: begin
            if (rom_ack_in) begin
               state_next = prog_sess_in ? rcp_pkg::RCP_READY :
                            rcp_pkg::RCP_IDLE;
            end
         end
         rcp_pkg::RCP_READY: begin
            if (!prog_sess_in) begin
               state_next = rcp_pkg::RCP_IDLE;
            end else if (pass) begin
               state_next = rcp_pkg::RCP_BUSY;
            end
         end
         rcp_pkg::RCP_BUSY: begin
            if (rom_ack_in) begin
               state_next = prog_sess_in ? rcp_pkg::RCP_READY :
                            rcp_pkg::RCP_IDLE;
            end
         end
         default: state_next = rcp_pkg::RCP_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= rcp_pkg::RCP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // protection level, loaded once per session and held
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prot_reg <= rcp_pkg::RCP_PROT_ALL;
      end else if (state_reg == rcp_pkg::RCP_IDLE) begin
         prot_reg <= rcp_pkg::RCP_PROT_ALL;
      end else if (state_reg == rcp_pkg::RCP_FETCH && rom_ack_in) begin
         prot_reg <= prot_next;
      end
   end

   // ROM side: protect byte fetch or a permitted access
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rom_req_out <= 1'b0;
         rom_we_out <= 1'b0;
         rom_addr_out <= `RCP_ADDR_RST;
         rom_wdata_out <= `RCP_DATA_RST;
      end else if (state_reg == rcp_pkg::RCP_IDLE && prog_sess_in) begin
         rom_req_out <= 1'b1;
         rom_we_out <= 1'b0;
         rom_addr_out <= `RCP_PROT_ADDR;
         rom_wdata_out <= `RCP_DATA_RST;
      end else if (pass) begin
         rom_req_out <= 1'b1;
         rom_we_out <= prog_we_in;
         rom_addr_out <= prog_addr_in;
         rom_wdata_out <= prog_wdata_in;
      end else begin
         rom_req_out <= 1'b0;
      end
   end

   // programmer side answers
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prog_ack_out <= 1'b0;
         prog_deny_out <= 1'b0;
         prog_rdata_out <= `RCP_DATA_RST;
      end else begin
         prog_deny_out <= deny;
         prog_ack_out <= (state_reg == rcp_pkg::RCP_BUSY) && rom_ack_in;
         if (state_reg == rcp_pkg::RCP_BUSY && rom_ack_in) begin
            prog_rdata_out <= rom_we_out ? `RCP_DATA_RST : rom_rdata_in;
         end
      end
   end

   // status flops
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prog_busy_out <= 1'b1;
         prog_open_out <= 1'b0;
         prot_level_out <= rcp_pkg::RCP_PROT_ALL;
      end else begin
         prog_busy_out <= (state_next != rcp_pkg::RCP_READY);
         prog_open_out <= (state_next == rcp_pkg::RCP_READY);
         prot_level_out <= (state_reg == rcp_pkg::RCP_FETCH && rom_ack_in) ?
                           prot_next : prot_reg;
      end
   end

   // protect byte is fetched right at session start
   a_fetch_at_start: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (state_reg == rcp_pkg::RCP_IDLE && prog_sess_in) |=>
      (rom_req_out && !rom_we_out && rom_addr_out == `RCP_PROT_ADDR &&
       state_reg == rcp_pkg::RCP_FETCH))
      else $error("protect byte fetch missing");

   // full protection refuses any ROM address
   a_all_refused: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (take && prot_reg == rcp_pkg::RCP_PROT_ALL && in_rom) |=>
      (prog_deny_out && !rom_req_out))
      else $error("access passed under full protection");

   // area one refused inclusive of its top address
   a_area1_refused: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (take && prot_reg == rcp_pkg::RCP_PROT_AREA1 &&
       prog_addr_in <= `RCP_AREA1_HI) |=> (prog_deny_out && !rom_req_out))
      else $error("area one access passed");

   // above area one is open under area protection
   a_area1_above: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (take && prot_reg == rcp_pkg::RCP_PROT_AREA1 &&
       prog_addr_in > `RCP_AREA1_HI) |=>
      (rom_req_out && !prog_deny_out && rom_addr_out == $past(prog_addr_in)))
      else $error("access above area one refused");

   // no protection forwards every access
   a_none_open: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (take && prot_reg == rcp_pkg::RCP_PROT_NONE) |=>
      (rom_req_out && !prog_deny_out && rom_we_out == $past(prog_we_in)))
      else $error("access refused without protection");

   // decode of the fetched protect byte
   a_decode_byte: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (state_reg == rcp_pkg::RCP_FETCH && rom_ack_in) |=>
      (prot_reg == (($past(rom_rdata_in) == `RCP_CODE_NONE) ?
                    rcp_pkg::RCP_PROT_NONE :
                    ($past(rom_rdata_in) == `RCP_CODE_AREA1) ?
                    rcp_pkg::RCP_PROT_AREA1 : rcp_pkg::RCP_PROT_ALL)))
      else $error("protect byte decoded wrongly");

   // level held while the session stays open
   a_level_held: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (state_reg == rcp_pkg::RCP_READY && prog_sess_in) |=>
      $stable(prot_reg))
      else $error("protection changed inside a session");

   // refused access never reaches the ROM and never acks
   a_deny_quiet: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      prog_deny_out |-> (!rom_req_out && !prog_ack_out && !prog_busy_out))
      else $error("refused access leaked to ROM");

   // permitted read completes one cycle after ROM ack, with the ROM data
   a_ack_return: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (state_reg == rcp_pkg::RCP_BUSY && rom_ack_in && !rom_we_out) |=>
      (prog_ack_out && prog_rdata_out == $past(rom_rdata_in)))
      else $error("read answer missing");

endmodule : rcp_gate

// ---- rcp_pkg.sv ----
package rcp_pkg;

   // gate sequencing
   typedef enum logic [1:0] {
      RCP_IDLE,
      RCP_FETCH,
      RCP_READY,
      RCP_BUSY
   } rcp_state_t;

   // decoded protection level
   typedef enum logic [1:0] {
      RCP_PROT_ALL,
      RCP_PROT_AREA1,
      RCP_PROT_NONE
   } rcp_prot_t;

endpackage : rcp_pkg

// ---- rcp_rom_model.sv ----
`timescale 1ns/1ps

module rcp_rom_model (
   input wire logic clk_in, // gate clock
   input wire logic req_in, // rom access pulse
   input wire logic [15:0] addr_in, // rom address
   input wire logic [7:0] code_in, // protect byte content
   input wire logic [3:0] wait_in, // extra answer delay
   output logic ack_out, // done pulse
   output logic [7:0] rdata_out // read data
);
   logic [15:0] a;
   initial begin
      ack_out = 1'b0;
      rdata_out = 8'h00;
   end
   // answer each pulse, then scramble the data lines
   always begin
      @(posedge clk_in);
      if (req_in === 1'b1) begin
         a = addr_in;
         repeat (wait_in) @(posedge clk_in);
         @(negedge clk_in);
         ack_out = 1'b1;
         rdata_out = (a == 16'hFFDB) ? code_in : a[7:0] ^ a[15:8];
         @(negedge clk_in);
         ack_out = 1'b0;
         rdata_out = ~rdata_out;
      end
   end
endmodule : rcp_rom_model

// ---- tb_rcp_gate.sv ----
`timescale 1ns/1ps
`include "rcp_consts.svh"

module tb_rcp_gate;
   logic clk = 1'b0, rst_b = 1'b0, sess = 1'b0, req = 1'b0, we = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] rom_addr;
   logic [7:0] wdata = 8'h00, code = 8'hFF, rdata, rom_rdata, rwd;
   logic busy, ack, deny, open, rom_req, rom_we, rom_ack;
   logic [1:0] lvl;
   logic [3:0] dly = 4'h0;
   int mismatches = 0, total_checks = 0;
   // 250 MHz clock
   always #2 clk = ~clk;
   rcp_gate uut (.sys_clk_in(clk), .rst_b_in(rst_b), .prog_sess_in(sess),
      .prog_req_in(req), .prog_we_in(we), .prog_addr_in(addr),
      .prog_wdata_in(wdata), .prog_busy_out(busy), .prog_ack_out(ack),
      .prog_deny_out(deny), .prog_rdata_out(rdata), .prog_open_out(open),
      .prot_level_out(lvl), .rom_req_out(rom_req), .rom_we_out(rom_we),
      .rom_addr_out(rom_addr), .rom_wdata_out(rwd), .rom_ack_in(rom_ack),
      .rom_rdata_in(rom_rdata));
   rcp_rom_model rom (.clk_in(clk), .req_in(rom_req), .addr_in(rom_addr),
      .code_in(code), .wait_in(dly), .ack_out(rom_ack),
      .rdata_out(rom_rdata));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // open a session, protect byte fetched from its fixed place
   task automatic open_sess(input logic [7:0] c, input logic [1:0] e);
      int i;
      @(negedge clk);
      code = c;
      sess = 1'b1;
      for (i = 0; i < 20 && busy !== 1'b0; i++) begin
         @(negedge clk);
         if (rom_req === 1'b1) begin
            chk({rom_we, rom_addr[14:0]}, 16'h7FDB);
         end
      end
      if (i == 20) begin
         mismatches++;
         tally_and_finish();
      end
      chk({open, 13'h0, lvl}, {1'b1, 13'h0, e});
   endtask : open_sess
   task automatic close_sess;
      int i;
      @(negedge clk);
      sess = 1'b0;
      for (i = 0; i < 10 && (open !== 1'b0 || lvl !== 2'h0); i++) begin
         @(negedge clk);
      end
      if (i == 10) begin
         mismatches++;
         tally_and_finish();
      end
      chk({busy, open, 12'h000, lvl}, 16'h8000);
   endtask : close_sess
   // one byte access, refused or served by the rom
   task automatic access(input logic w, input logic [15:0] a, input logic r);
      int i;
      logic [7:0] d;
      logic saw;
      d = a[7:0] ^ a[15:8];
      saw = 1'b0;
      @(negedge clk);
      req = 1'b1;
      we = w;
      addr = a;
      wdata = ~d;
      @(negedge clk);
      req = 1'b0;
      for (i = 0; i < 30 && ack !== 1'b1 && deny !== 1'b1; i++) begin
         if (rom_req === 1'b1) begin
            saw = 1'b1;
            chk(rom_addr, a);
            if (w) chk({7'h00, rom_we, rwd}, {8'h01, ~d});
         end
         @(negedge clk);
      end
      if (i == 30) begin
         mismatches++;
         tally_and_finish();
      end
      chk({deny, 7'h00, saw, 7'h00}, {r, 7'h00, ~r, 7'h00});
      if (!r) chk(16'(rdata), w ? 16'(`RCP_DATA_RST) : 16'(d));
   endtask : access
   task automatic t_reset;
      chk({busy, open, ack, deny, 10'h000, lvl}, 16'h8000);
      $display("reset test done");
   endtask : t_reset
   task automatic t_all;
      open_sess(`RCP_CODE_ALL, 2'h0);
      access(1'b0, 16'h0000, 1'b1);
      access(1'b1, 16'hFFFF, 1'b1);
      access(1'b0, 16'hF000, 1'b1);
      close_sess();
      $display("full protect test done");
   endtask : t_all
   task automatic t_area1;
      open_sess(`RCP_CODE_AREA1, 2'h1);
      access(1'b0, `RCP_AREA1_HI, 1'b1);
      access(1'b1, 16'h0000, 1'b1);
      access(1'b0, 16'hF000, 1'b0);
      dly = 4'h5;
      access(1'b1, 16'hF000, 1'b0);
      dly = 4'h0;
      close_sess();
      $display("area one test done");
   endtask : t_area1
   task automatic t_none;
      open_sess(`RCP_CODE_NONE, 2'h2);
      access(1'b0, 16'h0000, 1'b0);
      access(1'b1, `RCP_AREA1_HI, 1'b0);
      access(1'b0, 16'hFFFF, 1'b0);
      close_sess();
      $display("no protect test done");
   endtask : t_none
   // protect byte changes mid session, state must hold
   task automatic t_hold;
      open_sess(`RCP_CODE_AREA1, 2'h1);
      code = `RCP_CODE_NONE;
      access(1'b0, 16'h0100, 1'b1);
      close_sess();
      open_sess(`RCP_CODE_NONE, 2'h2);
      close_sess();
      $display("hold test done");
   endtask : t_hold
   // main sequence
   initial begin
      repeat (8) @(negedge clk);
      t_reset();
      rst_b = 1'b1;
      t_all();
      t_area1();
      t_none();
      t_hold();
      tally_and_finish();
   end
endmodule : tb_rcp_gate
